/* File: rtl/bcr_regs.svh */
// register offsets, field positions, reset values and timing constants of the configuration block
`ifndef BCR_REGS_SVH
`define BCR_REGS_SVH

// ****************************************
// map
// ****************************************
`define BCR_CFG_OFFSET      8'h04
`define BCR_CFG_RESET       16'h08a3
`define BCR_DATA_W          16

// ****************************************
// field positions
// ****************************************
`define BCR_RSVD_HI_BIT     15
`define BCR_PSEUDO_BIT      14
`define BCR_RATE_HI         13
`define BCR_RATE_LO         12
`define BCR_SPAN_HI         11
`define BCR_SPAN_LO         10
`define BCR_SRC_HI          9
`define BCR_SRC_LO          8
`define BCR_RAMP_HI         7
`define BCR_RAMP_LO         5
`define BCR_DITHER_HI       4
`define BCR_DITHER_LO       2
`define BCR_SMOOTH_BIT      1
`define BCR_RSVD_LO_BIT     0

// ****************************************
// ramp timing
// ****************************************
`define BCR_CLK_KHZ         125000
`define BCR_MS_PER_S        1000
`define BCR_CYC_PER_MS      (`BCR_CLK_KHZ * `BCR_MS_PER_S / `BCR_MS_PER_S)
`define BCR_RAMP_MS_1       10'd1
`define BCR_RAMP_MS_2       10'd2
`define BCR_RAMP_MS_3       10'd50
`define BCR_RAMP_MS_4       10'd100
`define BCR_RAMP_MS_5       10'd200
`define BCR_RAMP_MS_6       10'd300
`define BCR_RAMP_MS_7       10'd500
`define BCR_STEP_SHIFT      8
`define BCR_SMOOTH_SHIFT    2
`define BCR_SMOOTH_STRETCH  1

`endif

/* File: rtl/bcr_pkg.sv */
// types shared by the configuration register and the brightness ramp
package bcr_pkg;

  typedef enum logic [1:0] {
    BCR_RATE_200HZ = 2'b00,
    BCR_RATE_500HZ = 2'b01,
    BCR_RATE_800HZ = 2'b10,
    BCR_RATE_1K2HZ = 2'b11
  } bcr_rate_e;

  typedef enum logic [1:0] {
    BCR_SPAN_3P3 = 2'b00,
    BCR_SPAN_4P3 = 2'b01,
    BCR_SPAN_5P3 = 2'b10,
    BCR_SPAN_7P2 = 2'b11
  } bcr_span_e;

  typedef enum logic [1:0] {
    BCR_SRC_PWM_PIN = 2'b00,
    BCR_SRC_RSVD1   = 2'b01,
    BCR_SRC_REG     = 2'b10,
    BCR_SRC_RSVD3   = 2'b11
  } bcr_src_e;

  typedef enum logic [0:0] {
    BCR_RAMP_IDLE = 1'b0,
    BCR_RAMP_SLEW = 1'b1
  } bcr_ramp_state_e;

  typedef logic [2:0] bcr_code3_t;

endpackage

/* File: rtl/bcr_ramp.sv */
// brightness sloper: moves the output level toward a new target over the chosen duration, or about twice that with smoothing on
`timescale 1ns/100ps
`include "bcr_regs.svh"

module bcr_ramp #(
  parameter int unsigned CYC_PER_MS = `BCR_CYC_PER_MS
) (
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic [15:0]        target,
  input  wire bcr_pkg::bcr_code3_t ramp_code,
  input  wire logic               smooth_en,
  output logic      [15:0]        level,
  output logic                    busy
);
  import bcr_pkg::*;

  bcr_ramp_state_e state_r, state_nxt;
  logic [31:0]     cnt_r, cnt_nxt;
  logic [15:0]     cur_r, cur_nxt;
  logic [15:0]     step_r, step_nxt;
  logic [15:0]     tgt_r, tgt_nxt;
  logic [15:0]     lvl_r, lvl_nxt;
  logic [31:0]     interval;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // move a toward b by at most s, never by less than one count
  function automatic logic [15:0] approach(input logic [15:0] a, input logic [15:0] b, input logic [15:0] s);
    logic [15:0] d;
    logic [15:0] m;
    d = absdiff(a, b);
    m = (s == 16'h0000) ? 16'h0001 : s;
    if (d <= m) approach = b;
    else if (b > a) approach = a + m;
    else approach = a - m;
  endfunction

  function automatic logic [9:0] ramp_ms(input bcr_code3_t c);
    case (c)
      3'h1:    ramp_ms = `BCR_RAMP_MS_1;
      3'h2:    ramp_ms = `BCR_RAMP_MS_2;
      3'h3:    ramp_ms = `BCR_RAMP_MS_3;
      3'h4:    ramp_ms = `BCR_RAMP_MS_4;
      3'h5:    ramp_ms = `BCR_RAMP_MS_5;
      3'h6:    ramp_ms = `BCR_RAMP_MS_6;
      3'h7:    ramp_ms = `BCR_RAMP_MS_7;
      default: ramp_ms = 10'h000;
    endcase
  endfunction

  // ****************************************
  // step timing
  // ****************************************
  // full scale change takes 2^shift ticks; smoothing stretches the tick
  always_comb begin
    interval = (32'(ramp_ms(ramp_code)) * 32'(CYC_PER_MS)) >> `BCR_STEP_SHIFT;
    if (smooth_en) interval = interval << `BCR_SMOOTH_STRETCH;
    if (interval == 32'h0) interval = 32'h1;
  end

  // ****************************************
  // slew engine
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    cur_nxt   = cur_r;
    step_nxt  = step_r;
    tgt_nxt   = tgt_r;
    lvl_nxt   = lvl_r;
    if (ramp_code == 3'h0) begin
      // sloper off: brightness steps straight to the target
      state_nxt = BCR_RAMP_IDLE;
      cur_nxt   = target;
      tgt_nxt   = target;
      lvl_nxt   = target;
      cnt_nxt   = 32'h0;
    end else if (target != tgt_r) begin
      tgt_nxt   = target;
      step_nxt  = absdiff(target, cur_r) >> `BCR_STEP_SHIFT;
      state_nxt = BCR_RAMP_SLEW;
      cnt_nxt   = 32'h0;
    end else if (state_r == BCR_RAMP_SLEW) begin
      if (cnt_r >= interval - 32'h1) begin
        cnt_nxt = 32'h0;
        cur_nxt = approach(cur_r, tgt_r, step_r);
        if (smooth_en) lvl_nxt = approach(lvl_r, cur_nxt, absdiff(lvl_r, cur_nxt) >> `BCR_SMOOTH_SHIFT);
        else lvl_nxt = cur_nxt;
        if (lvl_nxt == tgt_r) state_nxt = BCR_RAMP_IDLE;
      end else begin
        cnt_nxt = cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= BCR_RAMP_IDLE;
      cnt_r   <= 32'h0;
      cur_r   <= 16'h0000;
      step_r  <= 16'h0000;
      tgt_r   <= 16'h0000;
      lvl_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      cur_r   <= cur_nxt;
      step_r  <= step_nxt;
      tgt_r   <= tgt_nxt;
      lvl_r   <= lvl_nxt;
    end
  end

  assign level = lvl_r;
  assign busy  = (state_r == BCR_RAMP_SLEW);

  property p_ramp_no_jump;
    @(posedge ref_clk) disable iff (!nrst)
    (ramp_code != 3'h0 && $past(ramp_code) != 3'h0 && smooth_en == $past(smooth_en))
      |-> absdiff(level, $past(level)) <= ($past(step_r) > 16'h1 ? $past(step_r) : 16'h1) || !$past(busy);
  endproperty
  a_ramp_no_jump: assert property (p_ramp_no_jump) else $error("ramp level moved more than one step");

endmodule

/* File: rtl/bcr_top.sv */
// brightness and spread configuration register with its brightness sloper
// ****************************************
// ****************************************
`timescale 1ns/100ps
`include "bcr_regs.svh"

module bcr_top #(
  parameter int unsigned CYC_PER_MS = `BCR_CYC_PER_MS
) (
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  output logic      [15:0]         reg_rdata,
  output logic                     reg_rvalid,
  input  wire logic [15:0]         pwm_duty,
  input  wire logic [15:0]         register_brightness_value,
  output logic                     spread_pseudo_en,
  output bcr_pkg::bcr_rate_e       spread_modulation_rate,
  output bcr_pkg::bcr_span_e       spread_span,
  output bcr_pkg::bcr_src_e        brightness_source_select,
  output bcr_pkg::bcr_code3_t      ramp_duration,
  output bcr_pkg::bcr_code3_t      dither_depth,
  output logic                     smoothed_ramp_enable,
  output logic                     source_reserved,
  output logic      [15:0]         effective_brightness,
  output logic                     ramp_busy
);
  import bcr_pkg::*;

  logic [15:0] cfg_r, cfg_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [15:0] target;
  logic        cfg_hit;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `BCR_CFG_OFFSET);
  endfunction

  // ****************************************
  // register access
  // ****************************************
  assign cfg_hit = addr_hit(reg_addr);

  // all sixteen bits stored as written, reserved ones included
  always_comb begin
    cfg_nxt = cfg_r;
    if (reg_wr && cfg_hit) cfg_nxt = reg_wdata;
  end

  // unmapped reads answer zero; a read in a write cycle sees the old value
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      if (cfg_hit) rdata_nxt = cfg_r;
      else rdata_nxt = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r    <= `BCR_CFG_RESET;
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      cfg_r    <= cfg_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ****************************************
  // field decode
  // ****************************************
  assign spread_pseudo_en         = cfg_r[`BCR_PSEUDO_BIT];
  assign spread_modulation_rate   = bcr_rate_e'(cfg_r[`BCR_RATE_HI:`BCR_RATE_LO]);
  assign spread_span              = bcr_span_e'(cfg_r[`BCR_SPAN_HI:`BCR_SPAN_LO]);
  assign brightness_source_select = bcr_src_e'(cfg_r[`BCR_SRC_HI:`BCR_SRC_LO]);
  assign ramp_duration            = cfg_r[`BCR_RAMP_HI:`BCR_RAMP_LO];
  assign dither_depth             = cfg_r[`BCR_DITHER_HI:`BCR_DITHER_LO];
  assign smoothed_ramp_enable     = cfg_r[`BCR_SMOOTH_BIT];

  // ****************************************
  // brightness source
  // ****************************************
  // reserved source codes fall back to the pin so the panel never goes dark
  always_comb begin
    if (brightness_source_select == BCR_SRC_REG) target = register_brightness_value;
    else target = pwm_duty;
  end

  assign source_reserved = (brightness_source_select == BCR_SRC_RSVD1) ||
                           (brightness_source_select == BCR_SRC_RSVD3);

  // ****************************************
  // sloper
  // ****************************************
  // 1 and 2 ms with smoothing still run, only with a longer, softer glide
  bcr_ramp #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_ramp (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .target     (target),
    .ramp_code  (ramp_duration),
    .smooth_en  (smoothed_ramp_enable),
    .level      (effective_brightness),
    .busy       (ramp_busy)
  );

  // ****************************************
  // checks
  // ****************************************
  property p_reset_value;
    @(posedge ref_clk) $rose(nrst) |-> cfg_r == `BCR_CFG_RESET && !smoothed_ramp_enable == 1'b0;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("config not at reset value");

  property p_write_lands;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_wr && reg_addr == `BCR_CFG_OFFSET) |=> cfg_r == $past(reg_wdata);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write to config not stored");

  property p_stray_write;
    @(posedge ref_clk) disable iff (!nrst)
    !(reg_wr && reg_addr == `BCR_CFG_OFFSET) |=> $stable(cfg_r);
  endproperty
  a_stray_write: assert property (p_stray_write) else $error("config changed without a write");

  property p_read_back;
    @(posedge ref_clk) disable iff (!nrst)
    reg_rd |=> reg_rvalid && reg_rdata == (($past(reg_addr) == `BCR_CFG_OFFSET) ? $past(cfg_r) : 16'h0000);
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong");

  property p_pseudo;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_wr && reg_addr == `BCR_CFG_OFFSET) |=> spread_pseudo_en == $past(reg_wdata[`BCR_PSEUDO_BIT]);
  endproperty
  a_pseudo: assert property (p_pseudo) else $error("pseudo spread enable wrong");

  property p_rate_span;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_wr && reg_addr == `BCR_CFG_OFFSET) |=>
      spread_modulation_rate == $past(reg_wdata[`BCR_RATE_HI:`BCR_RATE_LO]) &&
      spread_span == $past(reg_wdata[`BCR_SPAN_HI:`BCR_SPAN_LO]);
  endproperty
  a_rate_span: assert property (p_rate_span) else $error("spread rate or span wrong");

  property p_dither_smooth;
    @(posedge ref_clk) disable iff (!nrst)
    (reg_wr && reg_addr == `BCR_CFG_OFFSET) |=>
      dither_depth == $past(reg_wdata[`BCR_DITHER_HI:`BCR_DITHER_LO]) &&
      smoothed_ramp_enable == $past(reg_wdata[`BCR_SMOOTH_BIT]) &&
      ramp_duration == $past(reg_wdata[`BCR_RAMP_HI:`BCR_RAMP_LO]);
  endproperty
  a_dither_smooth: assert property (p_dither_smooth) else $error("dither, ramp or smoothing field wrong");

  property p_source;
    @(posedge ref_clk) disable iff (!nrst)
    (ramp_duration == 3'h0 && $stable(target)) ##1 (ramp_duration == 3'h0) |->
      effective_brightness == ((brightness_source_select == BCR_SRC_REG) ? register_brightness_value : pwm_duty) ||
      !$stable(target);
  endproperty
  a_source: assert property (p_source) else $error("brightness source not followed");

  // a glide must start on the very next edge, before any tick can move the level
  property p_glide;
    @(posedge ref_clk) disable iff (!nrst)
    (ramp_duration != 3'h0 && !ramp_busy && $stable(ramp_duration) && $changed(target)) |=> ramp_busy;
  endproperty
  a_glide: assert property (p_glide) else $error("sloper did not start a glide");

  // an idle sloper with a steady target must never creep
  property p_idle_holds;
    @(posedge ref_clk) disable iff (!nrst)
    (!ramp_busy && ramp_duration != 3'h0 && $stable(target)) |=> $stable(effective_brightness);
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("brightness moved while sloper idle");

  property p_sloper_off;
    @(posedge ref_clk) disable iff (!nrst)
    ramp_duration == 3'h0 |=> !ramp_busy && effective_brightness == $past(target);
  endproperty
  a_sloper_off: assert property (p_sloper_off) else $error("disabled sloper did not follow target");

  property p_busy_needs_ramp;
    @(posedge ref_clk) disable iff (!nrst)
    ramp_busy |-> $past(ramp_duration) != 3'h0;
  endproperty
  a_busy_needs_ramp: assert property (p_busy_needs_ramp) else $error("glide running with sloper off");

  // read data is held so a slow host can still pick it up late
  property p_rdata_hold;
    @(posedge ref_clk) disable iff (!nrst)
    !reg_rd |=> $stable(reg_rdata) && !reg_rvalid;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");

endmodule

/* File: testbench/bcr_tb.sv */
// self-checking bench for the configuration register and its brightness sloper
`timescale 1ns/100ps

module testbench;
  import bcr_pkg::*;

  // 256 cycles per ms makes one ramp tick last one cycle per ms of ramp duration
  localparam int unsigned CPM    = 256;
  localparam int          LIN_50 = 256 * 50;

  logic        ref_clk;
  logic        nrst;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic [15:0] pwm_duty;
  logic [15:0] register_brightness_value;
  logic        pseudo_o;
  bcr_rate_e   rate_o;
  bcr_span_e   span_o;
  bcr_src_e    src_o;
  bcr_code3_t  ramp_o;
  bcr_code3_t  dither_o;
  logic        smooth_o;
  logic        rsvd_o;
  logic [15:0] eff_o;
  logic        ramp_busy;
  logic [15:0] exp_q[$];
  int          n_mismatch;
  int          total_checks;

  bcr_top #(.CYC_PER_MS(CPM)) dut_u (
    .ref_clk                   (ref_clk),
    .nrst                      (nrst),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_rdata                 (reg_rdata),
    .reg_rvalid                (reg_rvalid),
    .pwm_duty                  (pwm_duty),
    .register_brightness_value (register_brightness_value),
    .spread_pseudo_en          (pseudo_o),
    .spread_modulation_rate    (rate_o),
    .spread_span               (span_o),
    .brightness_source_select  (src_o),
    .ramp_duration             (ramp_o),
    .dither_depth              (dither_o),
    .smoothed_ramp_enable      (smooth_o),
    .source_reserved           (rsvd_o),
    .effective_brightness      (eff_o),
    .ramp_busy                 (ramp_busy)
  );

  always #4 ref_clk = ~ref_clk;

  // ****************************************
  // compare and verdict
  // ****************************************
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rd(input logic [15:0] got);
    logic [15:0] e;
    total_checks++;
    if (exp_q.size() == 0) begin
      n_mismatch++;
      $display("BAD t=%0t unexpected read data %h", $time, got);
    end else begin
      e = exp_q.pop_front();
      if (got !== e) begin
        n_mismatch++;
        $display("BAD t=%0t read got %h exp %h", $time, got, e);
      end
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // read data is judged where it appears, against the oldest note
  always @(posedge ref_clk) begin
    if (reg_rvalid === 1'b1) begin
      chk_rd(reg_rdata);
    end
  end

  // ****************************************
  // drivers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge ref_clk);
    reg_rd = 1'b0;
  endtask

  task automatic chk_fields(input logic [15:0] w);
    chk_val({15'h0, pseudo_o}, {15'h0, w[14]}, "pseudo");
    chk_val({14'h0, rate_o}, {14'h0, w[13:12]}, "rate");
    chk_val({14'h0, span_o}, {14'h0, w[11:10]}, "span");
    chk_val({14'h0, src_o}, {14'h0, w[9:8]}, "source");
    chk_val({15'h0, rsvd_o}, {15'h0, w[8]}, "reserved source");
    chk_val({13'h0, ramp_o}, {13'h0, w[7:5]}, "ramp");
    chk_val({13'h0, dither_o}, {13'h0, w[4:2]}, "dither");
    chk_val({15'h0, smooth_o}, {15'h0, w[1]}, "smooth");
  endtask

  // one glide toward tgt; n counts cycles that busy stays up
  task automatic glide(input logic [15:0] tgt, output int n);
    int k;
    @(negedge ref_clk);
    register_brightness_value = tgt;
    k = 0;
    n = 0;
    while (ramp_busy !== 1'b1 && k < 4) begin
      @(negedge ref_clk);
      k++;
    end
    chk_val({15'h0, ramp_busy}, 16'h0001, "glide start");
    chk_val({15'h0, eff_o === tgt}, 16'h0000, "stepped at once");
    while (ramp_busy === 1'b1 && n < 60000) begin
      @(negedge ref_clk);
      n++;
    end
    chk_val(eff_o, tgt, "glide end");
    chk_val({15'h0, ramp_busy}, 16'h0000, "glide never ended");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int          n_lin;
    int          n_smo;
    logic [15:0] w;
    ref_clk = 1'b0;
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    pwm_duty = 16'h0000;
    register_brightness_value = 16'h0000;
    n_mismatch = 0;
    total_checks = 0;
    void'($urandom(32'hfb42));
    repeat (16) @(negedge ref_clk);
    nrst = 1'b1;
    chk_fields(16'h08a3);
    rd(8'h04, 16'h08a3);
    // every legal code of every field; reserved bits kept at their reset values
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom);
      w[15] = 1'b0;
      w[14] = i[0];
      w[13:12] = i[1:0];
      w[11:10] = i[1:0];
      w[9:8] = {i[0], 1'b0};
      w[7:5] = i[2:0];
      w[4:2] = 3'(i % 5);
      w[1] = i[2];
      w[0] = 1'b1;
      wr(8'h04, w);
      chk_fields(w);
      rd(8'h04, w);
    end
    // unmapped offset: no effect, reads zero
    wr(8'h06, 16'($urandom));
    chk_fields(w);
    rd(8'h06, 16'h0000);
    // sloper off: brightness follows the selected source next cycle
    wr(8'h04, 16'h0201);
    @(negedge ref_clk);
    register_brightness_value = 16'($urandom) | 16'h0001;
    pwm_duty = ~register_brightness_value;
    @(negedge ref_clk);
    chk_val(eff_o, register_brightness_value, "register source");
    wr(8'h04, 16'h0001);
    @(negedge ref_clk);
    chk_val(eff_o, pwm_duty, "pin source");
    pwm_duty = 16'h0000;
    register_brightness_value = 16'h0000;
    repeat (2) @(negedge ref_clk);
    // 50 ms linear, then smoothed back down, then 1 ms linear
    wr(8'h04, 16'h0261);
    glide(16'hff00, n_lin);
    chk_val({15'h0, n_lin >= LIN_50 - 60 && n_lin <= LIN_50 + 60}, 16'h0001, "linear time");
    wr(8'h04, 16'h0263);
    glide(16'h0000, n_smo);
    chk_val({15'h0, n_smo > n_lin}, 16'h0001, "smoothed longer");
    wr(8'h04, 16'h0221);
    glide(16'hff00, n_lin);
    chk_val({15'h0, n_lin >= 236 && n_lin <= 280}, 16'h0001, "1 ms time");
    // reset in mid-run restores defaults
    repeat (3) @(negedge ref_clk);
    nrst = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk_fields(16'h08a3);
    chk_val(eff_o, 16'h0000, "brightness after reset");
    nrst = 1'b1;
    rd(8'h04, 16'h08a3);
    repeat (3) @(negedge ref_clk);
    chk_val(16'(exp_q.size()), 16'h0000, "reads left unanswered");
    report_and_stop();
  end

  // whole run is about 41k cycles; this leaves ample slack
  initial begin
    #(8 * 100000);
    n_mismatch++;
    $display("BAD t=%0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
